/* bench/burst_tx_model.sv */
// Transmitter model that sends burst preamble words over the valid/ready path.
module burst_tx_model (
   input wire logic core_clk,
   input wire logic in_ready,
   output logic in_valid,
   output logic [15:0] in_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      in_valid = 1'b0;
      in_data = 16'h0000;
   end
   // Holds the word until the block has taken it.
   task automatic send(input logic [15:0] w);
      in_valid <= 1'b1;
      in_data <= w;
      do @(posedge core_clk); while (in_ready !== 1'b1);
   endtask
   // A released data bus shows the inverse of the last word.
   task automatic release_bus();
      in_valid <= 1'b0;
      in_data <= ~in_data;
   endtask
   task automatic burst(input logic [15:0] info, input logic [15:0] len);
      send(16'hf872);
      send(16'h4e1f);
      send(info & 16'h1f9f);
      send(len);
      release_bus();
   endtask
endmodule

/* bench/tb_burst_info_field_decoder.sv */
// Testbench for the burst-info decoder.
module tb_burst_info_field_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rst_b = 1'b0, frame_tick = 1'b0, out_ready = 1'b1, mask = 1'b0;
   logic in_valid, in_ready, out_valid, perr, rsv, sne, det, irq;
   logic [15:0] in_data, out_data, info_cap, len_cap;
   logic [7:0] rd_addr = 8'h00, rd_data;
   logic [4:0] tinfo, dtype;
   int fails = 0, comparisons = 0, cyc = 0;
   always #4 core_clk = ~core_clk;
   burst_info_field_decoder #(.GAP_FRAMES(8)) burst_info_field_decoder_i (.core_clk(core_clk), .rst_b(rst_b),
      .frame_tick(frame_tick), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
      .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready), .stop_event_mask(mask),
      .rd_addr(rd_addr), .rd_data(rd_data), .burst_info_capture(info_cap), .length_code_capture(len_cap),
      .payload_error(perr), .type_info(tinfo), .data_type(dtype), .reserved_error(rsv),
      .stream_num_error(sne), .nonpcm_detect(det), .event_interrupt_out(irq));
   burst_tx_model burst_tx_model_i (.core_clk(core_clk), .in_ready(in_ready), .in_valid(in_valid),
      .in_data(in_data));
   task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         end_sim();
      end
   end
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      rd_addr <= a;
      repeat (2) @(posedge core_clk);
      chk("rd_data", 16'(rd_data), 16'(exp));
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         frame_tick <= 1'b1;
         @(posedge core_clk);
         frame_tick <= 1'b0;
         @(posedge core_clk);
      end
      @(posedge core_clk);
   endtask
   task automatic burst_chk(input logic [15:0] info, input logic [15:0] len);
      burst_tx_model_i.burst(info, len);
      repeat (6) @(posedge core_clk);
      chk("info", info_cap, info);
      chk("len", len_cap, len);
      chk("perr", 16'(perr), 16'(info[7]));
      chk("tinfo", 16'(tinfo), 16'(info[12:8]));
      chk("dtype", 16'(dtype), 16'(info[4:0]));
      chk("rsv", 16'(rsv), 16'h0000);
      chk("sne", 16'(sne), 16'h0000);
      chk("det_irq", 16'({det, irq}), 16'h0002);
      rd(8'h3c, info[7:0]);
      rd(8'h3d, info[15:8]);
      rd(8'h3e, len[7:0]);
      rd(8'h3f, len[15:8]);
      rd(8'h40, 8'h00);
   endtask
   task automatic test_bursts();
      burst_chk(16'h1f85, 16'h1234);
      burst_chk(16'h0a03, 16'habcd);
      $display("test bursts done");
   endtask
   // A wrong second sync word and a repeated first one precede a burst with reserved and stream bits set.
   task automatic test_bad_bits();
      burst_tx_model_i.send(16'hf872);
      burst_tx_model_i.send(16'h0000);
      burst_tx_model_i.send(16'hf872);
      burst_tx_model_i.send(16'hf872);
      burst_tx_model_i.send(16'h4e1f);
      burst_tx_model_i.send(16'he065);
      burst_tx_model_i.send(16'h0010);
      burst_tx_model_i.release_bus();
      repeat (6) @(posedge core_clk);
      chk("bad_info", info_cap, 16'he065);
      chk("bad_len", len_cap, 16'h0010);
      chk("bad_rsv", 16'(rsv), 16'h0001);
      chk("bad_sne", 16'(sne), 16'h0001);
      chk("bad_dtype", 16'(dtype), 16'h0005);
      chk("bad_perr", 16'(perr), 16'h0000);
      chk("bad_tinfo", 16'(tinfo), 16'h0000);
      $display("test bad bits done");
   endtask
   task automatic test_reset();
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("rst_info", info_cap, 16'h0000);
      chk("rst_len", len_cap, 16'h0000);
      chk("rst_flags", 16'({in_ready, out_valid, det, irq, perr, rsv, sne}), 16'h0040);
      chk("rst_fields", 16'({tinfo, dtype}), 16'h0000);
      $display("test reset done");
   endtask
   task automatic test_gap(input logic m);
      mask <= m;
      burst_chk(16'h0c81, 16'h0800);
      ticks(7);
      chk("det_early", 16'({det, irq}), 16'h0002);
      ticks(1);
      chk("det_gap", {det, irq}, {14'h0000, 1'b0, ~m});
      $display("test gap done");
   endtask
   task automatic test_stall();
      out_ready <= 1'b0;
      burst_tx_model_i.send(16'h1111);
      burst_tx_model_i.send(16'h2222);
      burst_tx_model_i.release_bus();
      @(posedge core_clk);
      chk("full", 16'({in_ready, out_valid}), 16'h0001);
      chk("word1", out_data, 16'h1111);
      out_ready <= 1'b1;
      @(posedge core_clk);
      @(posedge core_clk);
      chk("word2", out_data, 16'h2222);
      $display("test stall done");
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge core_clk);
      test_bursts();
      test_bad_bits();
      test_gap(1'b0);
      test_gap(1'b1);
      test_stall();
      test_reset();
      end_sim();
   end
endmodule

/* logic/burst_info_field_decoder.sv */
// Burst-info word decoder with burst cadence watchdog and byte readback.
`include "burst_info_regs.svh"
module burst_info_field_decoder
   import burst_info_pkg::*;
#(
   parameter int GAP_FRAMES = `BIF_GAP_FRAMES
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic frame_tick,
   input wire logic in_valid,
   input wire logic [15:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [15:0] out_data,
   input wire logic out_ready,
   input wire logic stop_event_mask,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   output logic [15:0] burst_info_capture,
   output logic [15:0] length_code_capture,
   output logic payload_error,
   output logic [4:0] type_info,
   output logic [4:0] data_type,
   output logic reserved_error,
   output logic stream_num_error,
   output logic nonpcm_detect,
   output logic event_interrupt_out
);
   // Two-entry buffer in the word path; the parser snoops words as they leave.
   logic [15:0] mem_q [2];
   logic [15:0] mem_d [2];
   logic wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
   logic [1:0] count_q, count_d;
   logic in_ready_q, in_ready_d, out_valid_q, out_valid_d;
   logic [15:0] out_data_q, out_data_d;
   logic push, pop;

   assign push = in_valid && in_ready_q;
   assign pop = out_valid_q && out_ready;

   always_comb begin
      mem_d = mem_q;
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      count_d = count_q;
      if (push) begin
         mem_d[wr_ptr_q] = in_data;
         wr_ptr_d = ~wr_ptr_q;
      end
      if (pop) begin
         rd_ptr_d = ~rd_ptr_q;
      end
      if (push && !pop) begin
         count_d = count_q + 2'h1;
      end else if (pop && !push) begin
         count_d = count_q - 2'h1;
      end
      in_ready_d = (count_d != 2'h2);
      out_valid_d = (count_d != 2'h0);
      out_data_d = mem_d[rd_ptr_d];
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         mem_q[0] <= 16'h0000;
         mem_q[1] <= 16'h0000;
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'h0;
         in_ready_q <= 1'b0;
         out_valid_q <= 1'b0;
         out_data_q <= 16'h0000;
      end else begin
         mem_q <= mem_d;
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q <= count_d;
         in_ready_q <= in_ready_d;
         out_valid_q <= out_valid_d;
         out_data_q <= out_data_d;
      end
   end

   assign in_ready = in_ready_q;
   assign out_valid = out_valid_q;
   assign out_data = out_data_q;

   // Preamble parser, captures, cadence watchdog and readback.
   parse_state_e state_q, state_d;
   logic [15:0] info_hold_q, info_hold_d;
   logic [15:0] pc_q, pc_d, pd_q, pd_d;
   logic err_q, err_d, rsv_q, rsv_d, strm_q, strm_d;
   logic [4:0] info_q, info_d, dtype_q, dtype_d;
   logic [12:0] gap_q, gap_d;
   logic detect_q, detect_d, irq_q, irq_d;
   logic [7:0] rd_q, rd_d;
   logic burst_done;

   assign burst_done = pop && (state_q == TAKE_LENGTH);

   always_comb begin
      state_d = state_q;
      info_hold_d = info_hold_q;
      pc_d = pc_q;
      pd_d = pd_q;
      gap_d = gap_q;
      detect_d = detect_q;
      irq_d = irq_q;
      if (pop) begin
         case (state_q)
            SEEK_SYNC1: begin
               if (out_data_q == `BIF_SYNC_WORD_1) begin
                  state_d = SEEK_SYNC2;
               end
            end
            SEEK_SYNC2: begin
               if (out_data_q == `BIF_SYNC_WORD_2) begin
                  state_d = TAKE_INFO;
               end else if (out_data_q != `BIF_SYNC_WORD_1) begin
                  state_d = SEEK_SYNC1;
               end
            end
            TAKE_INFO: begin
               info_hold_d = out_data_q;
               state_d = TAKE_LENGTH;
            end
            TAKE_LENGTH: begin
               state_d = SEEK_SYNC1;
            end
            default: begin
               state_d = SEEK_SYNC1;
            end
         endcase
      end
      if (burst_done) begin
         pc_d = info_hold_q;
         pd_d = out_data_q;
         gap_d = 13'h0000;
         detect_d = 1'b1;
         irq_d = 1'b0;
      end else if (frame_tick && detect_q) begin
         if (32'(gap_q) + 32'h1 >= 32'(GAP_FRAMES)) begin
            detect_d = 1'b0;
            gap_d = 13'h0000;
            irq_d = !stop_event_mask;
         end else begin
            gap_d = gap_q + 13'h0001;
         end
      end
      err_d = pc_d[`BIF_ERR_BIT];
      rsv_d = |pc_d[`BIF_RSV_HI:`BIF_RSV_LO];
      strm_d = |pc_d[`BIF_STREAM_HI:`BIF_STREAM_LO];
      info_d = pc_d[`BIF_INFO_HI:`BIF_INFO_LO];
      dtype_d = pc_d[`BIF_TYPE_HI:0];
      case (rd_addr)
         `BIF_PC_LO_ADDR: rd_d = pc_q[7:0];
         `BIF_PC_HI_ADDR: rd_d = pc_q[15:8];
         `BIF_PD_LO_ADDR: rd_d = pd_q[7:0];
         `BIF_PD_HI_ADDR: rd_d = pd_q[15:8];
         default: rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_q <= SEEK_SYNC1;
         info_hold_q <= 16'h0000;
         pc_q <= 16'h0000;
         pd_q <= 16'h0000;
         err_q <= 1'b0;
         rsv_q <= 1'b0;
         strm_q <= 1'b0;
         info_q <= 5'h00;
         dtype_q <= 5'h00;
         gap_q <= 13'h0000;
         detect_q <= 1'b0;
         irq_q <= 1'b0;
         rd_q <= 8'h00;
      end else begin
         state_q <= state_d;
         info_hold_q <= info_hold_d;
         pc_q <= pc_d;
         pd_q <= pd_d;
         err_q <= err_d;
         rsv_q <= rsv_d;
         strm_q <= strm_d;
         info_q <= info_d;
         dtype_q <= dtype_d;
         gap_q <= gap_d;
         detect_q <= detect_d;
         irq_q <= irq_d;
         rd_q <= rd_d;
      end
   end

   assign burst_info_capture = pc_q;
   assign length_code_capture = pd_q;
   assign payload_error = err_q;
   assign reserved_error = rsv_q;
   assign stream_num_error = strm_q;
   assign type_info = info_q;
   assign data_type = dtype_q;
   assign nonpcm_detect = detect_q;
   assign event_interrupt_out = irq_q;
   assign rd_data = rd_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   error_flag_a: assert property (payload_error == burst_info_capture[`BIF_ERR_BIT])
      else $error("payload error flag differs from captured bit 7");
   type_info_a: assert property (burst_done |=> type_info == $past(info_hold_q[`BIF_INFO_HI:`BIF_INFO_LO]))
      else $error("type dependent bits not kept");
   gap_timeout_a: assert property (frame_tick && detect_q && !burst_done && 32'(gap_q) == GAP_FRAMES - 1
      |=> !nonpcm_detect)
      else $error("detect flag not cleared after frame gap");
   gap_hold_a: assert property (frame_tick && detect_q && 32'(gap_q) < GAP_FRAMES - 1 |=> nonpcm_detect)
      else $error("detect flag cleared early");
   stop_irq_a: assert property ($fell(nonpcm_detect) |-> event_interrupt_out == !$past(stop_event_mask))
      else $error("stop interrupt does not follow mask");
   info_read_a: assert property (rd_addr == `BIF_PC_HI_ADDR |=> rd_data == $past(pc_q[15:8]))
      else $error("info high byte readback wrong");
   burst_capture_a: assert property (burst_done |=> length_code_capture == $past(out_data_q)
      && burst_info_capture == $past(info_hold_q) ##1 nonpcm_detect)
      else $error("capture not refreshed by new burst");
endmodule

/* logic/burst_info_pkg.sv */
// Types shared by the burst-info decoder.
package burst_info_pkg;
   typedef enum logic [1:0] {
      SEEK_SYNC1 = 2'b00,
      SEEK_SYNC2 = 2'b01,
      TAKE_INFO = 2'b10,
      TAKE_LENGTH = 2'b11
   } parse_state_e;
endpackage

/* logic/burst_info_regs.svh */
// Offsets, field positions and timing counts of the burst-info decoder.
`ifndef BURST_INFO_REGS_SVH
`define BURST_INFO_REGS_SVH
`define BIF_SYNC_WORD_1 16'hf872
`define BIF_SYNC_WORD_2 16'h4e1f
`define BIF_GAP_FRAMES 4096
`define BIF_ERR_BIT 7
`define BIF_RSV_LO 5
`define BIF_RSV_HI 6
`define BIF_INFO_LO 8
`define BIF_INFO_HI 12
`define BIF_TYPE_HI 4
`define BIF_STREAM_LO 13
`define BIF_STREAM_HI 15
`define BIF_PC_LO_ADDR 8'h3c
`define BIF_PC_HI_ADDR 8'h3d
`define BIF_PD_LO_ADDR 8'h3e
`define BIF_PD_HI_ADDR 8'h3f
`endif
